// file: core/upl_regs.svh
// register offsets, field positions, reset values and counts of the user pattern bank
`ifndef UPL_REGS_SVH
`define UPL_REGS_SVH
`define UPL_NUM_CH 17
`define UPL_PAT_BITS 24
`define UPL_PAT_LAST 5'h17
`define UPL_CH0_GROUP 5'h1F
`define UPL_IDX_LOW 6'h12
`define UPL_IDX_MID 6'h13
`define UPL_IDX_HIGH 6'h14
`define UPL_IDX_IBL 6'h15
`define UPL_GENLEN_LSB 4
`define UPL_ACTLEN_LSB 2
`define UPL_DEALEN_LSB 0
`define UPL_PAT_RST 24'h000000
`define UPL_IBL_RST 6'h00
`define UPL_DET_USER 2'h3
`define UPL_RESP_OKAY 2'h0
`define UPL_RESP_SLVERR 2'h2
`endif

// file: core/upl_pkg.sv
// types shared by the user pattern bank
`default_nettype none
package upl_pkg;
  typedef struct packed {
    logic [23:0] pattern;
    logic [1:0] genLen;
    logic [1:0] actLen;
    logic [1:0] deactLen;
  } upl_chan_cfg_type;
  typedef struct packed {
    logic hit;
    logic [4:0] chan;
    logic [5:0] regIdx;
  } upl_decode_type;
endpackage
`default_nettype wire

// file: core/upl_regbank.sv
// per-channel user pattern and inband code length registers behind an axi4-lite slave
// Behaviour
// - three byte registers form one 24-bit user pattern feeding generator and detector.
// - the pattern is sent and checked bit 23 first and bit 0 last in every period.
// - low byte holds bits 7..0, middle byte 15..8, high byte 23..16.
// - bits 5..4 of the length register pick 5, 6, 7 or 8 low loop generation code bits.
// - bits 3..2 pick 5, 6, 7 or 8 low activate detection code bits, 5 after reset.
// - the detector compares against the user pattern when its select equals 11.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`include "upl_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module upl_regbank (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // axi4-lite write address and data
  input wire logic [12:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [12:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // per-channel configuration towards the pattern and inband logic
  output upl_pkg::upl_chan_cfg_type chanCfg [`UPL_NUM_CH],
  output logic [3:0] genCodeBits [`UPL_NUM_CH],
  output logic [3:0] actCodeBits [`UPL_NUM_CH],
  // serial pattern generation
  input wire logic [`UPL_NUM_CH-1:0] genTick,
  output logic [`UPL_NUM_CH-1:0] genBit,
  // serial pattern detection
  input wire logic [`UPL_NUM_CH-1:0] detTick,
  input wire logic [`UPL_NUM_CH-1:0] detData,
  input wire logic [1:0] detSelect [`UPL_NUM_CH],
  output logic [`UPL_NUM_CH-1:0] detMismatch
);
  import upl_pkg::*;

  // word index = byte address / 4; channels 1..16 sit in groups 0..15, channel 0 in group 1F
  function automatic upl_decode_type decode(input logic [12:0] addr);
    upl_decode_type d;
    d.regIdx = addr[7:2];
    d.chan = (addr[12:8] == `UPL_CH0_GROUP) ? 5'h00 : 5'(addr[12:8] + 5'h01);
    // groups past the last channel would index beyond the arrays, so they answer as unmapped
    d.hit = (d.regIdx >= `UPL_IDX_LOW) && (d.regIdx <= `UPL_IDX_IBL) &&
      ((addr[12:8] < 5'(`UPL_NUM_CH - 1)) || (addr[12:8] == `UPL_CH0_GROUP));
    return d;
  endfunction

  // 2-bit length code to number of valid low-order code bits
  function automatic logic [3:0] codeBits(input logic [1:0] len);
    return 4'(len) + 4'h5;
  endfunction

  logic [23:0] pat [`UPL_NUM_CH];
  logic [5:0] inband_code_length_control [`UPL_NUM_CH];
  logic [23:0] next_pat [`UPL_NUM_CH];
  logic [5:0] next_ibl [`UPL_NUM_CH];

  logic awHeld, wHeld, next_awHeld, next_wHeld;
  logic [12:0] awAddr, next_awAddr;
  logic [7:0] wByte, next_wByte;
  logic wLane, next_wLane;
  logic bValid, next_bValid;
  logic [1:0] bResp, next_bResp;
  logic rValid, next_rValid;
  logic [31:0] rData, next_rData;
  logic [1:0] rResp, next_rResp;

  assign s_axi_awready = !awHeld && !bValid;
  assign s_axi_wready = !wHeld && !bValid;
  assign s_axi_arready = !rValid;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;

  // register bus: address and data are caught in either order, write done once both are held
  always_comb begin
    upl_decode_type wd;
    upl_decode_type rd;
    wd = '0;
    rd = '0;
    next_pat = pat;
    next_ibl = inband_code_length_control;
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wByte = wByte;
    next_wLane = wLane;
    next_bValid = bValid;
    next_bResp = bResp;
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wByte = s_axi_wdata[7:0];
      next_wLane = s_axi_wstrb[0];
    end
    if (awHeld && wHeld) begin
      wd = decode(awAddr);
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = wd.hit ? `UPL_RESP_OKAY : `UPL_RESP_SLVERR;
      // per-channel copy
      // channel address select
      if (wd.hit && wLane) begin
        unique case (wd.regIdx)
          `UPL_IDX_LOW: next_pat[wd.chan][7:0] = wByte;
          `UPL_IDX_MID: next_pat[wd.chan][15:8] = wByte;
          `UPL_IDX_HIGH: next_pat[wd.chan][23:16] = wByte;
          // reserved bits 7..6 are not stored
          default: next_ibl[wd.chan] = wByte[5:0];
        endcase
      end
    end
    if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd = decode(s_axi_araddr);
      next_rValid = 1'b1;
      next_rResp = rd.hit ? `UPL_RESP_OKAY : `UPL_RESP_SLVERR;
      next_rData = 32'h00000000;
      if (rd.hit) begin
        unique case (rd.regIdx)
          `UPL_IDX_LOW: next_rData[7:0] = pat[rd.chan][7:0];
          `UPL_IDX_MID: next_rData[7:0] = pat[rd.chan][15:8];
          `UPL_IDX_HIGH: next_rData[7:0] = pat[rd.chan][23:16];
          default: next_rData[5:0] = inband_code_length_control[rd.chan];
        endcase
      end
    end else if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < `UPL_NUM_CH; c++) begin
        pat[c] <= `UPL_PAT_RST;
        // activate length 5 bits at reset
        inband_code_length_control[c] <= `UPL_IBL_RST;
      end
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 13'h0000;
      wByte <= 8'h00;
      wLane <= 1'b0;
      bValid <= 1'b0;
      bResp <= `UPL_RESP_OKAY;
      rValid <= 1'b0;
      rData <= 32'h00000000;
      rResp <= `UPL_RESP_OKAY;
    end else begin
      pat <= next_pat;
      inband_code_length_control <= next_ibl;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wByte <= next_wByte;
      wLane <= next_wLane;
      bValid <= next_bValid;
      bResp <= next_bResp;
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
    end
  end

  // configuration fan-out, straight from the stored registers
  always_comb begin
    for (int c = 0; c < `UPL_NUM_CH; c++) begin
      chanCfg[c].pattern = pat[c];
      chanCfg[c].genLen = inband_code_length_control[c][`UPL_GENLEN_LSB+:2];
      chanCfg[c].actLen = inband_code_length_control[c][`UPL_ACTLEN_LSB+:2];
      chanCfg[c].deactLen = inband_code_length_control[c][`UPL_DEALEN_LSB+:2];
      genCodeBits[c] = codeBits(inband_code_length_control[c][`UPL_GENLEN_LSB+:2]);
      actCodeBits[c] = codeBits(inband_code_length_control[c][`UPL_ACTLEN_LSB+:2]);
    end
  end

  // serial walk through the pattern; positions count down so bit 23 leads each period
  logic [4:0] genPos [`UPL_NUM_CH];
  logic [4:0] detPos [`UPL_NUM_CH];
  logic [4:0] next_genPos [`UPL_NUM_CH];
  logic [4:0] next_detPos [`UPL_NUM_CH];
  logic [`UPL_NUM_CH-1:0] next_genBit;
  logic [`UPL_NUM_CH-1:0] next_detMismatch;

  // a pattern rewrite mid-period takes effect at the next bit, not at the period start
  always_comb begin
    next_genPos = genPos;
    next_detPos = detPos;
    next_genBit = genBit;
    next_detMismatch = '0;
    for (int c = 0; c < `UPL_NUM_CH; c++) begin
      if (genTick[c]) begin
        next_genBit[c] = pat[c][genPos[c]];
        next_genPos[c] = (genPos[c] == 5'h00) ? `UPL_PAT_LAST : 5'(genPos[c] - 5'h01);
      end
      if (detTick[c]) begin
        next_detPos[c] = (detPos[c] == 5'h00) ? `UPL_PAT_LAST : 5'(detPos[c] - 5'h01);
        if (detSelect[c] == `UPL_DET_USER) begin
          next_detMismatch[c] = detData[c] != pat[c][detPos[c]];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < `UPL_NUM_CH; c++) begin
        genPos[c] <= `UPL_PAT_LAST;
        detPos[c] <= `UPL_PAT_LAST;
      end
      genBit <= '0;
      detMismatch <= '0;
    end else begin
      genPos <= next_genPos;
      detPos <= next_detPos;
      genBit <= next_genBit;
      detMismatch <= next_detMismatch;
    end
  end
endmodule
`default_nettype wire

// file: tb/upl_regbank_monitor.sv
// bus and channel checker for the user pattern bank
`include "upl_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module upl_regbank_monitor (
  // clock, reset and bus handshakes
  input wire logic mclk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // channel side
  input wire upl_pkg::upl_chan_cfg_type chanCfg [`UPL_NUM_CH],
  input wire logic [3:0] genCodeBits [`UPL_NUM_CH],
  input wire logic [3:0] actCodeBits [`UPL_NUM_CH],
  input wire logic [`UPL_NUM_CH-1:0] genTick,
  input wire logic [`UPL_NUM_CH-1:0] genBit,
  input wire logic [`UPL_NUM_CH-1:0] detTick,
  input wire logic [1:0] detSelect [`UPL_NUM_CH],
  input wire logic [`UPL_NUM_CH-1:0] detMismatch
);
  import upl_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_gen_len: assert property (genCodeBits[1] == {2'h0, chanCfg[1].genLen} + 4'h5)
    else $error("loop code length mismatch");
  chk_act_len: assert property (actCodeBits[1] == {2'h0, chanCfg[1].actLen} + 4'h5)
    else $error("activate code length mismatch");
  chk_reset_vals: assert property ($rose(resetn) |-> actCodeBits[1] == 4'h5 &&
    chanCfg[1].pattern == 24'h0) else $error("reset values wrong");
  chk_gen_hold: assert property (!genTick[1] |=> $stable(genBit[1]))
    else $error("generator bit moved without tick");
  chk_det_quiet: assert property ((!detTick[1] || detSelect[1] != 2'h3) |=> !detMismatch[1])
    else $error("mismatch without user pattern check");
  chk_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind upl_regbank upl_regbank_monitor mon_u (.mclk, .resetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .chanCfg, .genCodeBits,
  .actCodeBits, .genTick, .genBit, .detTick, .detSelect, .detMismatch);
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the user pattern bank
`include "upl_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  import upl_pkg::*;
  logic mclk, resetn, awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady;
  logic [12:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [1:0] bResp, rResp;
  logic [3:0] wStrb;
  upl_chan_cfg_type cfg [`UPL_NUM_CH];
  logic [3:0] genLen [`UPL_NUM_CH];
  logic [3:0] actLen [`UPL_NUM_CH];
  logic [1:0] detSel [`UPL_NUM_CH];
  logic [16:0] genTick, genBit, detTick, detData, detMis;
  logic [23:0] pat = 24'hC33CA5;
  int errTotal = 0;
  int samplesChecked = 0;
  int cycles = 0;
  upl_regbank dut_u (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .chanCfg(cfg),
    .genCodeBits(genLen), .actCodeBits(actLen), .genTick(genTick), .genBit(genBit),
    .detTick(detTick), .detData(detData), .detSelect(detSel), .detMismatch(detMis));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic testDone();
    $display("checks=%0d errors=%0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errTotal = errTotal + 1;
      testDone();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // response is accepted late on purpose so the slave must hold it
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic aw = 1'b0;
    logic w = 1'b0;
    awAddr <= a;
    wData <= {24'h0, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    do begin
      @(posedge mclk);
      aw |= awReady;
      w |= wReady;
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
    end while (!(aw && w));
    repeat (2) @(posedge mclk);
    bReady <= 1'b1;
    do @(posedge mclk); while (!bValid);
    bReady <= 1'b0;
    cmp(bResp, `UPL_RESP_OKAY);
  endtask
  task automatic rd(input logic [12:0] a, input logic [31:0] exp, input logic [1:0] er);
    arAddr <= a;
    arValid <= 1'b1;
    do @(posedge mclk); while (!arReady);
    arValid <= 1'b0;
    @(posedge mclk);
    rReady <= 1'b1;
    do @(posedge mclk); while (!rValid);
    rReady <= 1'b0;
    cmp(rData, exp);
    cmp(rResp, er);
  endtask
  initial begin
    {resetn, awValid, wValid, bReady, arValid, rReady} <= '0;
    {awAddr, arAddr, wData, genTick, detTick, detData} <= '0;
    wStrb <= 4'hF;
    detSel <= '{default: 2'h3};
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    cmp(actLen[1], 4'h5);
    rd(13'h054, 32'h0, `UPL_RESP_OKAY);
    wr(13'h048, 8'hA5);
    wr(13'h04C, 8'h3C);
    wr(13'h050, 8'hC3);
    wr(13'h1F48, 8'h5A);
    cmp(cfg[1].pattern, pat);
    cmp(cfg[0].pattern, 24'h00005A);
    cmp(cfg[2].pattern, 24'h0);
    rd(13'h04C, 32'h3C, `UPL_RESP_OKAY);
    rd(13'h0FC, 32'h0, `UPL_RESP_SLVERR);
    // a write without its low strobe must leave the byte alone
    wStrb <= 4'h0;
    wr(13'h048, 8'hFF);
    wStrb <= 4'hF;
    rd(13'h048, 32'hA5, `UPL_RESP_OKAY);
    for (int v = 0; v < 4; v++) begin
      wr(13'h054, {2'h0, v[1:0], ~v[1:0], 2'h0});
      cmp(genLen[1], v + 5);
      cmp(cfg[1].genLen, v[1:0]);
      cmp(actLen[1], 8 - v);
      cmp(cfg[1].actLen, 3 - v);
    end
    for (int i = 23; i >= 0; i--) begin
      genTick <= 17'h2;
      @(posedge mclk);
      genTick <= 17'h0;
      @(posedge mclk);
      cmp(genBit[1], pat[i]);
    end
    // second pass flips every bit but selects a non-user pattern
    for (int s = 0; s < 2; s++) begin
      detSel[1] <= s ? 2'h0 : 2'h3;
      for (int i = 23; i >= 0; i--) begin
        detTick <= 17'h2;
        detData <= {15'h0, pat[i] ^ (s == 1 || i == 10), 1'b0};
        @(posedge mclk);
        detTick <= 17'h0;
        @(posedge mclk);
        cmp(detMis[1], s == 0 && i == 10);
      end
    end
    // a mid-run reset must clear what was written
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    cmp(cfg[1].pattern, `UPL_PAT_RST);
    cmp(genLen[1], 4'h5);
    rd(13'h048, 32'h0, `UPL_RESP_OKAY);
    testDone();
  end
endmodule
`default_nettype wire
